/* File: cha_pkg.sv */
// constants shared by the card host access controller and its helpers
package cha_pkg;

  // ----------------------------------------------------------------
  // software register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_CMD    = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RDATA  = 4'h5;

  // ----------------------------------------------------------------
  // control register fields and reset value
  // ----------------------------------------------------------------
  localparam int CTRL_IDE    = 0;
  localparam int CTRL_IDX_LO = 1;
  localparam int CTRL_TWO    = 3;
  localparam int CTRL_DIRECT = 4;
  localparam int CTRL_SPD_LO = 5;
  localparam int CTRL_CAP_LO = 7;
  localparam int CTRL_PWR    = 9;
  localparam logic [9:0] CTRL_RESET = 10'h000;

  // ----------------------------------------------------------------
  // command register fields
  // ----------------------------------------------------------------
  localparam int CMD_WRITE  = 0;
  localparam int CMD_WID_LO = 1;
  localparam int CMD_CBLK   = 3;
  localparam int CMD_DMA    = 4;
  localparam int CMD_PAIR   = 5;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] WID_BYTE = 2'h0;
  localparam logic [1:0] WID_WORD = 2'h1;
  localparam logic [1:0] WID_ODD  = 2'h2;
  localparam logic [1:0] SPD_STD  = 2'h0;
  localparam logic [1:0] SPD_FAST = 2'h1;
  localparam logic [1:0] SPD_ADV  = 2'h2;
  localparam logic [1:0] IDX_MEM    = 2'h0;
  localparam logic [1:0] IDX_CONTIG = 2'h1;
  localparam logic [1:0] IDX_PRI    = 2'h2;
  localparam logic [1:0] IDX_SEC    = 2'h3;

  // ----------------------------------------------------------------
  // legacy block bases and drive address layout
  // ----------------------------------------------------------------
  localparam logic [10:0] PRI_TASK_BASE = 11'h1f0;
  localparam logic [10:0] PRI_CTRL_BASE = 11'h3f0;
  localparam logic [10:0] SEC_TASK_BASE = 11'h170;
  localparam logic [10:0] SEC_CTRL_BASE = 11'h370;
  localparam logic [2:0]  OFS_DRV_ADDR  = 3'h7;
  localparam int          DRV_FLOAT_BIT = 7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS          = 10;
  localparam int T_CYC_STD_NS    = 250;
  localparam int T_CYC_FAST_NS   = 120;
  localparam int T_CYC_ADV_NS    = 100;
  localparam int T_PWR_SETTLE_NS = 1000;
  localparam int CYC_STD  = (T_CYC_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_FAST = (T_CYC_FAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_ADV  = (T_CYC_ADV_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_PWR  = (T_PWR_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_FRAME = 2;  // setup plus recovery around the strobe

  // ----------------------------------------------------------------
  // cycle sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD   = 2'b11
  } cha_state_t;

endpackage

/* File: cha_sync.sv */
// two flip-flop synchroniser for the card data lanes
`timescale 1ns/1ps
module cha_sync #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // asynchronous input and synchronised copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // cha_sync

/* File: cha_host_ctrl.sv */
// host controller driving the storage card pins from a software register port
//
// Summary of operation
// - true IDE only if select pin held low through power-up
// - faster than 250 ns only if every card supports it
// - advanced modes only with one directly connected card, unless requested and supported speed fields are both 3
// - with two cards use fastest mode both support
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module cha_host_ctrl
  import cha_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // software port
  input  wire logic [3:0]  sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [31:0] sw_rdata,
  // card power and address pins
  output logic             card_power_en,
  output logic      [10:0] card_addr,
  output logic             attr_select_n,
  output logic             low_byte_enable_n,
  output logic             high_byte_enable_n,
  // card strobes and selects
  output logic             read_enable_n,
  output logic             write_enable_n,
  output logic             io_read_n,
  output logic             io_write_n,
  output logic             task_block_select_n,
  output logic             control_block_select_n,
  output logic             dma_grant_n,
  // card data lanes
  output logic      [15:0] data_out,
  output logic             data_oe_lo,
  output logic             data_oe_hi,
  input  wire logic [15:0] data_in
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [9:0]  ctrl_reg;
  logic [10:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [5:0]  cmd_reg;
  logic [15:0] rdata_reg;
  cha_state_t  state_reg;
  logic [7:0]  cnt_reg;
  logic        pair_second_reg;
  logic [1:0]  eff_spd_reg;
  logic        mode_ide_reg;
  logic [7:0]  pwr_cnt_reg;
  logic [15:0] data_sync;
  logic [1:0]  eff_spd_next;
  logic [1:0]  spd_min;
  logic        start;
  logic        pair_on;
  logic        is_write;
  logic [1:0]  width;

  // strobe low time per speed grade, in clock cycles
  function automatic logic [7:0] active_cycles(input logic [1:0] spd);
    case (spd)
      SPD_ADV:  active_cycles = 8'(CYC_ADV - CYC_FRAME);
      SPD_FAST: active_cycles = 8'(CYC_FAST - CYC_FRAME);
      default:  active_cycles = 8'(CYC_STD - CYC_FRAME);
    endcase
  endfunction

  // pin address for the selected mapping
  function automatic logic [10:0] form_addr(input logic [1:0] idx, input logic ide,
                                            input logic cblk, input logic [10:0] a);
    if (ide)
      form_addr = {8'h00, a[2:0]};
    else if (idx == IDX_MEM)
      form_addr = {7'h00, cblk, a[2:0]};
    else if (idx == IDX_CONTIG)
      form_addr = {a[10:4], cblk, a[2:0]};
    else if (idx == IDX_PRI)
      form_addr = (cblk ? PRI_CTRL_BASE : PRI_TASK_BASE) | {8'h00, a[2:0]};
    else
      form_addr = (cblk ? SEC_CTRL_BASE : SEC_TASK_BASE) | {8'h00, a[2:0]};
  endfunction

  cha_sync #(.W(16)) u_data_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .d       (data_in),
    .q       (data_sync)
  );

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  assign is_write = cmd_reg[CMD_WRITE];
  assign width    = cmd_reg[CMD_WID_LO +: 2];
  assign pair_on  = cmd_reg[CMD_PAIR] && (width == WID_BYTE);
  assign start    = sw_wr && (sw_addr == REG_CMD) && (state_reg == ST_IDLE) && card_power_en;

  // order register writes; a command while busy or unpowered is dropped
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg  <= CTRL_RESET;
      addr_reg  <= 11'h000;
      wdata_reg <= 16'h0000;
      cmd_reg   <= 6'h00;
    end else if (sw_wr) begin
      if (sw_addr == REG_CTRL)
        ctrl_reg <= sw_wdata[9:0];
      else if (sw_addr == REG_ADDR && state_reg == ST_IDLE)
        addr_reg <= sw_wdata[10:0];
      else if (sw_addr == REG_WDATA && state_reg == ST_IDLE)
        wdata_reg <= sw_wdata[15:0];
      else if (start)
        cmd_reg <= sw_wdata[5:0];
    end
  end

  // read data one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sw_rdata <= 32'h0000_0000;
    end else if (sw_rd) begin
      if (sw_addr == REG_CTRL)
        sw_rdata <= {22'h00_0000, ctrl_reg};
      else if (sw_addr == REG_ADDR)
        sw_rdata <= {21'h00_0000, addr_reg};
      else if (sw_addr == REG_WDATA)
        sw_rdata <= {16'h0000, wdata_reg};
      else if (sw_addr == REG_CMD)
        sw_rdata <= {26'h000_0000, cmd_reg};
      else if (sw_addr == REG_STATUS)
        sw_rdata <= {27'h000_0000, eff_spd_reg, mode_ide_reg, card_power_en, state_reg != ST_IDLE};
      else if (sw_addr == REG_RDATA)
        sw_rdata <= {16'h0000, rdata_reg};
      else
        sw_rdata <= 32'h0000_0000;
    end else begin
      sw_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // power sequencing and mode latch
  // ----------------------------------------------------------------
  // mode follows software only while power is off, so it is frozen across the on edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_ide_reg  <= 1'b0;
      pwr_cnt_reg   <= 8'h00;
      card_power_en <= 1'b0;
    end else if (!ctrl_reg[CTRL_PWR]) begin
      mode_ide_reg  <= ctrl_reg[CTRL_IDE];
      pwr_cnt_reg   <= 8'h00;
      card_power_en <= 1'b0;
    end else if (!card_power_en) begin
      if (pwr_cnt_reg == 8'(CYC_PWR - 1))
        card_power_en <= 1'b1;
      else
        pwr_cnt_reg <= pwr_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // speed grade choice
  // ----------------------------------------------------------------
  // fastest grade all cards share; advanced only for one direct card, unless both speed fields are 3, which clamps to advanced unchecked
  always_comb begin
    spd_min = (ctrl_reg[CTRL_SPD_LO +: 2] < ctrl_reg[CTRL_CAP_LO +: 2]) ?
              ctrl_reg[CTRL_SPD_LO +: 2] : ctrl_reg[CTRL_CAP_LO +: 2];
    if (spd_min > SPD_ADV)
      eff_spd_next = SPD_ADV;
    else if (spd_min == SPD_ADV && (ctrl_reg[CTRL_TWO] || !ctrl_reg[CTRL_DIRECT]))
      eff_spd_next = SPD_FAST;
    else
      eff_spd_next = spd_min;
  end

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg       <= ST_IDLE;
      cnt_reg         <= 8'h00;
      pair_second_reg <= 1'b0;
      eff_spd_reg     <= SPD_STD;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg       <= ST_SETUP;
            eff_spd_reg     <= eff_spd_next;
            pair_second_reg <= 1'b0;
          end
        end
        ST_SETUP: begin
          state_reg <= ST_STROBE;
          cnt_reg   <= active_cycles(eff_spd_reg) - 8'h01;
        end
        ST_STROBE: begin
          if (cnt_reg == 8'h00)
            state_reg <= ST_HOLD;
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
        default: begin
          if (pair_on && !pair_second_reg) begin
            state_reg       <= ST_SETUP;
            pair_second_reg <= 1'b1;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drive, registered one cycle behind the sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      card_addr              <= 11'h000;
      attr_select_n          <= 1'b1;
      low_byte_enable_n      <= 1'b1;
      high_byte_enable_n     <= 1'b1;
      read_enable_n          <= 1'b1;
      write_enable_n         <= 1'b1;
      io_read_n              <= 1'b1;
      io_write_n             <= 1'b1;
      task_block_select_n    <= 1'b1;
      control_block_select_n <= 1'b1;
      dma_grant_n            <= 1'b1;
      data_out               <= 16'h0000;
      data_oe_lo             <= 1'b0;
      data_oe_hi             <= 1'b0;
    end else begin
      // ide mode keeps the shared read/select pin grounded throughout
      read_enable_n          <= !mode_ide_reg;
      write_enable_n         <= 1'b1;
      io_read_n              <= 1'b1;
      io_write_n             <= 1'b1;
      attr_select_n          <= 1'b1;
      low_byte_enable_n      <= 1'b1;
      high_byte_enable_n     <= 1'b1;
      task_block_select_n    <= 1'b1;
      control_block_select_n <= 1'b1;
      dma_grant_n            <= 1'b1;
      data_oe_lo             <= 1'b0;
      data_oe_hi             <= 1'b0;
      if (state_reg != ST_IDLE) begin
        card_addr <= form_addr(ctrl_reg[CTRL_IDX_LO +: 2], mode_ide_reg, cmd_reg[CMD_CBLK], addr_reg);
        // second byte of a pair carries the odd half on the lower lane
        data_out  <= {wdata_reg[15:8], pair_second_reg ? wdata_reg[15:8] : wdata_reg[7:0]};
        if (mode_ide_reg) begin
          // dma grant excludes both selects, and only one select at a time
          if (cmd_reg[CMD_DMA])
            dma_grant_n <= 1'b0;
          else if (cmd_reg[CMD_CBLK])
            control_block_select_n <= 1'b0;
          else
            task_block_select_n <= 1'b0;
          io_read_n  <= !(state_reg == ST_STROBE && !is_write);
          io_write_n <= !(state_reg == ST_STROBE && is_write);
          data_oe_lo <= is_write;
          data_oe_hi <= is_write && (width != WID_BYTE);
        end else begin
          attr_select_n      <= (ctrl_reg[CTRL_IDX_LO +: 2] == IDX_MEM);
          low_byte_enable_n  <= (width == WID_ODD);
          high_byte_enable_n <= (width == WID_BYTE);
          if (ctrl_reg[CTRL_IDX_LO +: 2] == IDX_MEM) begin
            read_enable_n  <= !(state_reg == ST_STROBE && !is_write);
            write_enable_n <= !(state_reg == ST_STROBE && is_write);
          end else begin
            io_read_n  <= !(state_reg == ST_STROBE && !is_write);
            io_write_n <= !(state_reg == ST_STROBE && is_write);
          end
          data_oe_lo <= is_write && (width != WID_ODD);
          data_oe_hi <= is_write && (width != WID_BYTE);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read capture at recovery, lanes by width
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 16'h0000;
    end else if (state_reg == ST_HOLD && !is_write) begin
      if (width == WID_WORD)
        rdata_reg <= data_sync;
      else if (width == WID_ODD)
        rdata_reg[15:8] <= data_sync[15:8];
      else if (pair_second_reg)
        rdata_reg[15:8] <= data_sync[7:0];
      else if (cmd_reg[CMD_CBLK] && addr_reg[2:0] == OFS_DRV_ADDR)
        rdata_reg[7:0] <= {1'b0, data_sync[DRV_FLOAT_BIT-1:0]};
      else
        rdata_reg[7:0] <= data_sync[7:0];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence pair_first_s;
    state_reg == ST_HOLD && pair_on && !pair_second_reg;
  endsequence
  sequence pair_second_s;
    state_reg == ST_SETUP && pair_second_reg ##1 (!is_write || data_out[7:0] == wdata_reg[15:8]);
  endsequence

  select_exclusive_a: assert property (task_block_select_n || control_block_select_n)
    else $error("both block selects low");
  grant_alone_a: assert property (!dma_grant_n |-> task_block_select_n && control_block_select_n)
    else $error("dma grant with a block select");
  speed_caps_a: assert property (state_reg != ST_IDLE |-> eff_spd_reg <= ctrl_reg[CTRL_CAP_LO +: 2])
    else $error("speed above card capability");
  adv_single_a: assert property (state_reg != ST_IDLE && eff_spd_reg == SPD_ADV |-> !ctrl_reg[CTRL_TWO] && ctrl_reg[CTRL_DIRECT])
    else $error("advanced speed with shared or cabled card");
  adv_strobe_a: assert property ($fell(io_read_n) |-> !io_read_n [*8])
    else $error("read strobe shorter than fastest cycle");
  fastest_common_a: assert property (start ##1 1'b1 |-> eff_spd_reg == $past(eff_spd_next))
    else $error("speed not taken from common grade");
  ide_powerup_a: assert property ($rose(card_power_en) && mode_ide_reg |-> $past(read_enable_n, 2) == 1'b0)
    else $error("select pin not low at power on");
  mode_frozen_a: assert property (card_power_en && $past(card_power_en) |-> $stable(mode_ide_reg))
    else $error("mode changed while powered");
  pair_order_a: assert property (pair_first_s |=> pair_second_s)
    else $error("paired byte order wrong");

endmodule // cha_host_ctrl

/* File: cha_card_model.sv */
// behavioural storage card answering the host controller pins
`timescale 1ns/1ps
module cha_card_model #(
  parameter logic [7:0] ERR_VAL  = 8'h5a,
  parameter logic [7:0] STAT_VAL = 8'h50,
  parameter logic [7:0] DRV_VAL  = 8'hc3
) (
  // power and address
  input  wire logic        card_power_en,
  input  wire logic [10:0] card_addr,
  input  wire logic        attr_select_n,
  input  wire logic        low_byte_enable_n,
  input  wire logic        high_byte_enable_n,
  // strobes and selects
  input  wire logic        read_enable_n,
  input  wire logic        write_enable_n,
  input  wire logic        io_read_n,
  input  wire logic        io_write_n,
  input  wire logic        task_block_select_n,
  input  wire logic        control_block_select_n,
  input  wire logic        dma_grant_n,
  // data lanes
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe_lo,
  input  wire logic        data_oe_hi,
  output logic      [15:0] data_in
);
  logic        ide = 1'b0;
  logic [7:0]  regs [16];
  logic [7:0]  fifo [16];
  logic [3:0]  ptr = 4'h0;
  logic [3:0]  o;
  logic [15:0] m, v;
  logic [15:0] keep = 16'h0;
  logic        rd_n, wr_n, sel, word, hio;
  logic        rd_q = 1'b1, wr_q = 1'b1;

  // ----------------------------------------
  // mode and decode
  // ----------------------------------------
  always @(posedge card_power_en) ide <= !read_enable_n;
  assign rd_n = (ide || !attr_select_n) ? io_read_n : read_enable_n;
  assign wr_n = (ide || !attr_select_n) ? io_write_n : write_enable_n;
  assign sel  = ide ? !(task_block_select_n && control_block_select_n && dma_grant_n)
                    : !(low_byte_enable_n && high_byte_enable_n);
  assign hio  = !ide && low_byte_enable_n && !high_byte_enable_n;
  assign word = ide ? (o == 4'h0) : !(low_byte_enable_n || high_byte_enable_n);
  // duplicates fold onto their base offsets
  always_comb begin
    if (ide) o = dma_grant_n ? {!control_block_select_n, card_addr[2:0]} : 4'h0;
    else if (card_addr[9:4] == 6'h3f || card_addr[9:4] == 6'h37) o = {1'b1, card_addr[2:0]};
    else o = card_addr[3:0];
    if (o == 4'h8) o = 4'h0;
    if (o == 4'hd || (hio && o == 4'h0)) o = 4'h1;
  end

  function automatic logic [7:0] rv(input logic [3:0] i);
    case (i)
      4'h0:       return fifo[ptr];
      4'h1:       return ERR_VAL;
      4'h7, 4'he: return STAT_VAL;
      4'hf:       return DRV_VAL;
      default:    return regs[i];
    endcase
  endfunction

  // ----------------------------------------
  // lanes: a released lane shows the inverse of its last level
  // ----------------------------------------
  always_comb begin
    m = {{8{data_oe_hi}}, {8{data_oe_lo}}};
    v = data_out;
    if (card_power_en && sel && !rd_n) begin
      if (!hio) begin
        m[7:0] = 8'hff;
        v[7:0] = word ? fifo[ptr] : rv(o);
      end
      if (hio || word) begin
        m[15:8] = 8'hff;
        v[15:8] = word ? fifo[ptr + 4'h1] : rv(o | 4'h1);
      end
      if (o == 4'hf) m[7] = 1'b0;
    end
  end
  always @(m, v) for (int b = 0; b < 16; b++) if (m[b]) keep[b] = ~v[b];
  assign data_in = (m & v) | (~m & keep);

  // data port steps through the buffer like a fifo; one process owns the pointer
  always @(rd_n, wr_n) begin
    if (rd_n && !rd_q && card_power_en && sel && o == 4'h0) ptr <= ptr + (word ? 4'h2 : 4'h1);
    if (wr_n && !wr_q && card_power_en && sel) begin
    if (word) begin
      fifo[ptr] <= data_in[7:0];
      fifo[ptr + 4'h1] <= data_in[15:8];
      ptr <= ptr + 4'h2;
    end
    else if (hio) regs[o | 4'h1] <= data_in[15:8];
    else if (o == 4'h0) begin
      fifo[ptr] <= data_in[7:0];
      ptr <= ptr + 4'h1;
    end
    else regs[o] <= data_in[7:0];
      if (o == 4'h7) ptr <= 4'h0;  // a command restarts the buffer
    end
    rd_q = rd_n;
    wr_q = wr_n;
  end
endmodule  // cha_card_model

/* File: card_host_access_decode_tb_top.sv */
// self-checking bench for the card host access controller
`timescale 1ns/1ps
module card_host_access_decode_tb_top;
  import cha_pkg::*;
  localparam logic [7:0] ERR_V = 8'h5a;
  localparam logic [7:0] STAT_V = 8'h50;
  localparam logic [7:0] DRV_V = 8'hc3;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [31:0] sw_rdata, r;
  logic [10:0] card_addr;
  logic [15:0] data_out, data_in;
  logic        card_power_en, attr_select_n, low_byte_enable_n, high_byte_enable_n, read_enable_n;
  logic        write_enable_n, io_read_n, io_write_n, task_block_select_n, control_block_select_n;
  logic        dma_grant_n, data_oe_lo, data_oe_hi;
  logic [6:0]  base = 7'h20;
  logic [7:0]  sp [5] = '{8'haa, 8'had, 8'ha1, 8'h69, 8'h18};
  int          miscompares = 0;
  int          num_checks = 0;

  cha_host_ctrl i_dut (.clk_sys, .resetn, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata,
    .card_power_en, .card_addr, .attr_select_n, .low_byte_enable_n, .high_byte_enable_n,
    .read_enable_n, .write_enable_n, .io_read_n, .io_write_n, .task_block_select_n,
    .control_block_select_n, .dma_grant_n, .data_out, .data_oe_lo, .data_oe_hi, .data_in);
  cha_card_model #(.ERR_VAL(ERR_V), .STAT_VAL(STAT_V), .DRV_VAL(DRV_V)) i_card (.card_power_en,
    .card_addr, .attr_select_n, .low_byte_enable_n, .high_byte_enable_n, .read_enable_n,
    .write_enable_n, .io_read_n, .io_write_n, .task_block_select_n, .control_block_select_n,
    .dma_grant_n, .data_out, .data_oe_lo, .data_oe_hi, .data_in);

  initial forever #5 clk_sys = ~clk_sys;

  // ----------------------------------------
  // software port tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // a spare edge after each strobe keeps drivers from double assignment
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
    @(posedge clk_sys);
  endtask
  // one card transfer: load, issue, poll busy under a bound, fetch result
  task automatic cyc(input logic [5:0] c, input logic [2:0] o, input logic [15:0] d, output logic [31:0] q);
    wr(REG_ADDR, {21'h0, base, 1'b0, o});
    wr(REG_WDATA, {16'h0, d});
    wr(REG_CMD, {26'h0, c});
    repeat (60) begin
      rd(REG_STATUS, q);
      if (q[0] === 1'b0) break;
    end
    chk(q & 32'h1, 32'h0);
    rd(REG_RDATA, q);
  endtask
  task automatic complete_run();
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(REG_CTRL, r);
    chk(r, {22'h0, CTRL_RESET});
    rd(4'hf, r);
    chk(r, 32'h0);
    wr(REG_CMD, 32'h1);  // dropped while unpowered
    rd(REG_STATUS, r);
    chk(r, 32'h0);
    wr(REG_CTRL, 32'h200);
    repeat (120) @(posedge clk_sys);
    // memory, contiguous, primary and secondary maps in turn
    for (int k = 0; k < 4; k++) begin
      wr(REG_CTRL, {22'h0, 7'h40, k[1:0], 1'b0});
      rd(REG_STATUS, r);
      chk(r & 32'h7, 32'h2);
      cyc(6'h01, 3'h4, {8'h0, 6'h10, k[1:0]}, r);
      cyc(6'h00, 3'h4, 16'h0, r);
      chk(r & 32'hff, {24'h0, 6'h10, k[1:0]});
      cyc(6'h08, 3'h6, 16'h0, r);
      chk(r & 32'hff, {24'h0, STAT_V});
      cyc(6'h08, 3'h7, 16'h0, r);
      chk(r & 32'hff, {24'h0, DRV_V & 8'h7f});
      cyc(6'h01, 3'h7, 16'h00ec, r);
      cyc(6'h21, 3'h0, 16'habcd, r);
      cyc(6'h03, 3'h0, 16'h1234, r);
      cyc(6'h01, 3'h7, 16'h00ec, r);
      cyc(6'h02, 3'h0, 16'h0, r);
      chk(r & 32'hffff, 32'habcd);
      cyc(6'h20, 3'h0, 16'h0, r);
      chk(r & 32'hffff, 32'h1234);
      cyc(6'h04, 3'h0, 16'h0, r);
      chk(r & 32'hff00, {16'h0, ERR_V, 8'h0});
      cyc(6'h05, 3'h5, 16'h9600, r);
      cyc(6'h00, 3'h5, 16'h0, r);
      chk(r & 32'hff, 32'h96);
    end
    // select held low through power-up gives the task-file interface
    wr(REG_CTRL, 32'h1);
    repeat (20) @(posedge clk_sys);
    wr(REG_CTRL, 32'h201);
    repeat (120) @(posedge clk_sys);
    rd(REG_STATUS, r);
    chk(r & 32'h7, 32'h6);
    cyc(6'h01, 3'h5, 16'h0077, r);
    cyc(6'h00, 3'h5, 16'h0, r);
    chk(r & 32'hff, 32'h77);
    cyc(6'h08, 3'h6, 16'h0, r);
    chk(r & 32'hff, {24'h0, STAT_V});
    cyc(6'h01, 3'h7, 16'h00ec, r);
    cyc(6'h13, 3'h0, 16'h5a3c, r);
    cyc(6'h01, 3'h7, 16'h00ec, r);
    cyc(6'h12, 3'h0, 16'h0, r);
    chk(r & 32'hffff, 32'h5a3c);
    // speed table: supported, requested, direct, two cards against effective
    foreach (sp[i]) begin
      wr(REG_CTRL, {22'h0, 1'b1, sp[i][7:2], 3'h1});
      // the effective grade is latched when a card cycle starts
      cyc(6'h08, 3'h6, 16'h0, r);
      chk(r & 32'hff, {24'h0, STAT_V});
      rd(REG_STATUS, r);
      chk(r & 32'h18, {27'h0, sp[i][1:0], 3'h0});
    end
    complete_run();
  end

  // hang guard well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end
endmodule  // card_host_access_decode_tb_top
